/* hdl/gated_timer.sv */
// gated 16-bit up timer/counter with selectable source, prescaler and gate
// assumes control bits and byte writes arrive synchronous to sys_clk_in
//
// Behaviour
// - 16-bit count, byte writes replace live bytes
// - on bit off stops; gate enable needs gate
// - clock select picks one of four sources
// - system clock gives four counts per instruction
// - external pin counts rising edges, sync optional
// - external mode needs falling edge before counting
// - prescale 1/2/4/8, hidden, cleared by writes
// - sync disable bypasses the pin synchroniser for the count pin only
// - async external counting continues through sleep
// - sync switch may drop or add one
// - count bytes read back from registers
// - gated mode counts only while gate active
// - polarity bit sets the active gate level
// - gate source: pin or companion overflow
// - companion FFh to 00h wrap makes pulse
// - toggle flip-flop flips on source rising edge
// - toggle flip-flop held clear when mode off
// - rollover FFFFh to 0000h sets overflow flag
// - on bit clear also clears toggle flip-flop

`timescale 1ns/1ps
`default_nettype none

module gated_timer
	import gtimer_pkg::*;
(
	// clock and reset
	input  wire logic                  sys_clk_in,
	input  wire logic                  rst_in,
	// control bits
	input  wire logic                  timer_on_bit_in,
	input  wire logic                  gate_enable_bit_in,
	input  wire logic [1:0]            clock_select_field_in,
	input  wire logic [1:0]            prescale_select_field_in,
	input  wire logic                  sync_disable_bit_in,
	input  wire logic                  gate_polarity_bit_in,
	input  wire logic                  gate_source_select_bit_in,
	input  wire logic                  toggle_mode_bit_in,
	// count byte writes
	input  wire logic                  count_low_wr_in,
	input  wire logic                  count_high_wr_in,
	input  wire logic [BYTE_W-1:0]     count_wr_data_in,
	// overflow flag clear and sleep state
	input  wire logic                  overflow_flag_clr_in,
	input  wire logic                  sleep_in,
	// clock and gate sources
	input  wire logic                  external_count_pin_in,
	input  wire logic                  external_gate_pin_in,
	input  wire logic                  low_freq_internal_osc_in,
	input  wire logic [BYTE_W-1:0]     companion_timer_count_in,
	// count readback
	output logic      [BYTE_W-1:0]     count_low_byte_out,
	output logic      [BYTE_W-1:0]     count_high_byte_out,
	// status
	output logic                       overflow_flag_out,
	output logic                       wake_out,
	output logic                       gate_value_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [COUNT_W-1:0] count_ff;
	logic [PSC_W-1:0]   psc_ff;
	logic [1:0]         instr_div_ff;
	logic               armed_ff;
	logic               async_prev_ff;
	logic               lfosc_prev_ff;
	logic [BYTE_W-1:0]  comp_prev_ff;
	logic               comp_pulse_ff;
	logic               gsrc_prev_ff;
	logic               toggle_ff;
	logic               overflow_ff;
	logic               wake_ff;

	logic [COUNT_W-1:0] nxt_count;
	logic [PSC_W-1:0]   psc_mask;
	logic               any_write;
	logic               instr_tick;
	logic               lfosc_tick;
	logic               ext_rise;
	logic               ext_fall;
	logic               ext_level;
	logic               src_tick;
	logic               psc_tick;
	logic               gate_src;
	logic               gate_src_rise;
	logic               gate_val;
	logic               gate_active;
	logic               count_en;
	logic               inc;
	logic               ext_mode;
	logic               async_ext;
	logic               awake_src;

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	pin_sync_if #(.N(PIN_N)) pins ();

	assign pins.raw[PIN_COUNT] = external_count_pin_in;
	assign pins.raw[PIN_GATE]  = external_gate_pin_in;

	pin_sync #(
		.N (PIN_N)
	) u_pin_sync (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.pins       (pins)
	);

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	assign any_write = count_low_wr_in | count_high_wr_in;
	assign ext_mode  = (clock_select_field_in == CLKSEL_EXTPIN);
	assign async_ext = ext_mode & sync_disable_bit_in;
	// only the async external path keeps running while asleep
	assign awake_src = ~sleep_in | async_ext;

	// ------------------------------------------------------------
	// instruction clock divider: one pulse every four system clocks
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			instr_div_ff <= 2'h0;
		end else begin
			instr_div_ff <= instr_div_ff + 2'h1;
		end
	end
	assign instr_tick = (instr_div_ff == INSTR_LAST);

	// ------------------------------------------------------------
	// low-frequency oscillator edge detect
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			lfosc_prev_ff <= 1'b0;
		end else begin
			lfosc_prev_ff <= low_freq_internal_osc_in;
		end
	end
	assign lfosc_tick = low_freq_internal_osc_in & ~lfosc_prev_ff;

	// ------------------------------------------------------------
	// bypass path: one flop of history on the raw count pin
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			async_prev_ff <= 1'b0;
		end else begin
			async_prev_ff <= external_count_pin_in;
		end
	end

	// choose synchronised or bypassed edges of the count pin
	always_comb begin
		if (sync_disable_bit_in) begin
			ext_level = external_count_pin_in;
			ext_rise  = external_count_pin_in & ~async_prev_ff;
			ext_fall  = ~external_count_pin_in & async_prev_ff;
		end else begin
			ext_level = pins.level[PIN_COUNT];
			ext_rise  = pins.rise[PIN_COUNT];
			ext_fall  = pins.fall[PIN_COUNT];
		end
	end

	// ------------------------------------------------------------
	// falling-edge arming for external counter mode
	// ------------------------------------------------------------
	// disarmed after reset, any count write and while the timer is off
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || any_write || !timer_on_bit_in) begin
			armed_ff <= 1'b0;
		end else if (ext_fall && !ext_level) begin
			armed_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// clock source select
	// ------------------------------------------------------------
	always_comb begin
		case (clock_select_field_in)
			CLKSEL_LFOSC:  src_tick = lfosc_tick;
			CLKSEL_EXTPIN: src_tick = ext_rise & armed_ff;
			CLKSEL_SYSOSC: src_tick = 1'b1;
			default:       src_tick = instr_tick;
		endcase
	end

	// ------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------
	always_comb begin
		case (prescale_select_field_in)
			PSC_DIV2: psc_mask = 3'h1;
			PSC_DIV4: psc_mask = 3'h3;
			PSC_DIV8: psc_mask = 3'h7;
			default:  psc_mask = 3'h0;
		endcase
	end

	// a prescaled tick comes out once the low bits reach the mask
	assign psc_tick = src_tick && ((psc_ff & psc_mask) == psc_mask);

	// hidden counter; advances only on ticks that may count
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || any_write) begin
			psc_ff <= PSC_RST;
		end else if (src_tick && count_en && awake_src) begin
			psc_ff <= psc_ff + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// companion timer overflow pulse
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			comp_prev_ff  <= COMP_WRAP_LO;
			comp_pulse_ff <= 1'b0;
		end else begin
			comp_prev_ff  <= companion_timer_count_in;
			comp_pulse_ff <= (comp_prev_ff == COMP_WRAP_HI) &&
			                 (companion_timer_count_in == COMP_WRAP_LO);
		end
	end

	// ------------------------------------------------------------
	// gate path: source, toggle flip-flop, polarity
	// ------------------------------------------------------------
	assign gate_src = gate_source_select_bit_in ? comp_pulse_ff
	                                            : pins.level[PIN_GATE];

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			gsrc_prev_ff <= 1'b0;
		end else begin
			gsrc_prev_ff <= gate_src;
		end
	end
	assign gate_src_rise = gate_src & ~gsrc_prev_ff;

	// toggle flip-flop held clear while toggle mode or the timer is off
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !toggle_mode_bit_in || !timer_on_bit_in) begin
			toggle_ff <= 1'b0;
		end else if (gate_src_rise) begin
			toggle_ff <= ~toggle_ff;
		end
	end

	assign gate_val    = toggle_mode_bit_in ? toggle_ff : gate_src;
	assign gate_active = gate_polarity_bit_in ? gate_val : ~gate_val;

	// gate value status is visible whether or not gating is enabled
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			gate_value_out <= 1'b0;
		end else begin
			gate_value_out <= gate_active;
		end
	end

	// ------------------------------------------------------------
	// count enable
	// ------------------------------------------------------------
	// off stops everything; gate enable holds the count while inactive
	assign count_en = timer_on_bit_in && (!gate_enable_bit_in || gate_active);
	assign inc      = psc_tick && count_en && awake_src;

	// ------------------------------------------------------------
	// 16-bit count with byte writes
	// ------------------------------------------------------------
	always_comb begin
		nxt_count = count_ff;
		if (inc) begin
			nxt_count = count_ff + 16'h0001;
		end
		// a byte write replaces that byte of the live count
		if (count_low_wr_in) begin
			nxt_count[7:0] = count_wr_data_in;
		end
		if (count_high_wr_in) begin
			nxt_count[15:8] = count_wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			count_ff <= COUNT_RST;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// readback bytes straight from the count register
	assign count_low_byte_out  = count_ff[7:0];
	assign count_high_byte_out = count_ff[15:8];

	// ------------------------------------------------------------
	// overflow flag and wake
	// ------------------------------------------------------------
	// a rollover in the clear cycle still sets the flag
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			overflow_ff <= 1'b0;
		end else if (inc && count_ff == COUNT_MAX) begin
			overflow_ff <= 1'b1;
		end else if (overflow_flag_clr_in) begin
			overflow_ff <= 1'b0;
		end
	end
	assign overflow_flag_out = overflow_ff;

	// one-cycle wake pulse on a rollover while asleep
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= sleep_in && inc && (count_ff == COUNT_MAX);
		end
	end
	assign wake_out = wake_ff;

endmodule

`default_nettype wire

/* hdl/gtimer_pkg.sv */
// package for the gated 16-bit timer/counter
// holds clock source codes, prescale codes, reset values and cycle counts
// assumes nothing of its surroundings

package gtimer_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int COUNT_W = 16;
	localparam int BYTE_W  = 8;
	localparam int PSC_W   = 3;
	localparam int PIN_N   = 2;

	// ------------------------------------------------------------
	// clock source select codes
	// ------------------------------------------------------------
	localparam logic [1:0] CLKSEL_LFOSC  = 2'h3;
	localparam logic [1:0] CLKSEL_EXTPIN = 2'h2;
	localparam logic [1:0] CLKSEL_SYSOSC = 2'h1;
	localparam logic [1:0] CLKSEL_INSTR  = 2'h0;

	// ------------------------------------------------------------
	// prescale select codes: divide by 1, 2, 4, 8
	// ------------------------------------------------------------
	localparam logic [1:0] PSC_DIV1 = 2'h0;
	localparam logic [1:0] PSC_DIV2 = 2'h1;
	localparam logic [1:0] PSC_DIV4 = 2'h2;
	localparam logic [1:0] PSC_DIV8 = 2'h3;

	// ------------------------------------------------------------
	// counts and reset values
	// ------------------------------------------------------------
	localparam int             INSTR_DIV     = 4;
	localparam logic [1:0]     INSTR_LAST    = 2'h3;
	localparam logic [15:0]    COUNT_RST     = 16'h0000;
	localparam logic [15:0]    COUNT_MAX     = 16'hFFFF;
	localparam logic [2:0]     PSC_RST       = 3'h0;
	localparam logic [7:0]     COMP_WRAP_HI  = 8'hFF;
	localparam logic [7:0]     COMP_WRAP_LO  = 8'h00;

	// pin indexes inside the synchroniser
	localparam int PIN_COUNT = 0;
	localparam int PIN_GATE  = 1;

endpackage

/* hdl/pin_sync_if.sv */
// interface between the timer core and its pin synchroniser
// assumes one system clock; the core drives raw pins, the syncer returns edges

`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if #(
	parameter int N = 2
);
	logic [N-1:0] raw;
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;

	modport core (output raw, input level, input rise, input fall);
	modport syncer (input raw, output level, output rise, output fall);
endinterface

`default_nettype wire

/* hdl/pin_sync.sv */
// two-stage synchroniser with edge detection for the timer's pins
// assumes pins may change at any time relative to sys_clk_in

`timescale 1ns/1ps
`default_nettype none

module pin_sync
	import gtimer_pkg::*;
#(
	parameter int N = PIN_N
) (
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_in,
	// pin levels in, clean levels and edges out
	pin_sync_if.syncer pins
);

	logic [N-1:0] meta_ff;
	logic [N-1:0] stable_ff;
	logic [N-1:0] prev_ff;

	// ------------------------------------------------------------
	// per-pin synchroniser and edge detector
	// ------------------------------------------------------------
	for (genvar i = 0; i < N; i++) begin : g_pin
		// first stage feeds only the second stage
		always_ff @(posedge sys_clk_in) begin
			if (rst_in) begin
				meta_ff[i]   <= 1'b0;
				stable_ff[i] <= 1'b0;
				prev_ff[i]   <= 1'b0;
			end else begin
				meta_ff[i]   <= pins.raw[i];
				stable_ff[i] <= meta_ff[i];
				prev_ff[i]   <= stable_ff[i];
			end
		end

		// edges are seen on the clean stage only
		assign pins.level[i] = stable_ff[i];
		assign pins.rise[i]  = stable_ff[i] & ~prev_ff[i];
		assign pins.fall[i]  = ~stable_ff[i] & prev_ff[i];
	end

endmodule

`default_nettype wire

/* bench/gtimer_assertions.sv */
// concurrent checks on the gated timer's top-level ports
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module gtimer_assertions (
	// clock and reset
	input wire logic	sys_clk_in,
	input wire logic	rst_in,
	// control bits
	input wire logic	timer_on_bit_in,
	input wire logic	gate_enable_bit_in,
	input wire logic [1:0]	clock_select_field_in,
	input wire logic [1:0]	prescale_select_field_in,
	input wire logic	gate_polarity_bit_in,
	input wire logic	gate_source_select_bit_in,
	input wire logic	toggle_mode_bit_in,
	// writes, flag clear, sleep and gate pin
	input wire logic	count_low_wr_in,
	input wire logic	count_high_wr_in,
	input wire logic [7:0]	count_wr_data_in,
	input wire logic	overflow_flag_clr_in,
	input wire logic	sleep_in,
	input wire logic	external_gate_pin_in,
	// results
	input wire logic [7:0]	count_low_byte_out,
	input wire logic [7:0]	count_high_byte_out,
	input wire logic	overflow_flag_out,
	input wire logic	wake_out
);
	// ----------------------------------------
	// helper terms
	// ----------------------------------------
	wire logic [15:0] cnt = {count_high_byte_out, count_low_byte_out};
	wire logic no_wr = !count_low_wr_in && !count_high_wr_in;
	wire logic base = timer_on_bit_in && no_wr && !sleep_in && prescale_select_field_in == 2'h0;
	wire logic free = base && !gate_enable_bit_in;
	wire logic gated = base && gate_enable_bit_in && clock_select_field_in == 2'h1
		&& !gate_source_select_bit_in && !toggle_mode_bit_in;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_sys_tick; free && clock_select_field_in == 2'h1; endsequence
	sequence s_instr_run; (free && clock_select_field_in == 2'h0) [*4]; endsequence
	sequence s_gate_on; (gated && external_gate_pin_in == gate_polarity_bit_in) [*4]; endsequence
	sequence s_gate_off; (gated && external_gate_pin_in != gate_polarity_bit_in) [*4]; endsequence
	property p_reset_clear;
		@(posedge sys_clk_in) disable iff (1'b0)
		rst_in |=> cnt == 16'h0000 && !overflow_flag_out && !wake_out;
	endproperty
	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_write_low: assert property (count_low_wr_in |=> count_low_byte_out == $past(count_wr_data_in))
		else $error("low byte write not taken");
	a_write_high: assert property (count_high_wr_in |=> count_high_byte_out == $past(count_wr_data_in))
		else $error("high byte write not taken");
	a_off_holds: assert property (!timer_on_bit_in && no_wr |=> $stable(cnt))
		else $error("count moved while off");
	a_sys_rate: assert property (s_sys_tick |=> cnt == $past(cnt) + 16'h0001)
		else $error("system clock count missed");
	a_instr_rate: assert property (s_instr_run |=> cnt == $past(cnt, 4) + 16'h0001)
		else $error("instruction clock rate wrong");
	a_gate_counts: assert property (s_gate_on |=> cnt == $past(cnt) + 16'h0001)
		else $error("active gate did not count");
	a_gate_holds: assert property (s_gate_off |=> $stable(cnt))
		else $error("inactive gate counted");
	a_rollover_flag: assert property ($past(cnt) == 16'hFFFF && cnt == 16'h0000
		&& $past(no_wr) |-> overflow_flag_out)
		else $error("rollover did not set flag");
	a_flag_sticky: assert property (overflow_flag_out && !overflow_flag_clr_in |=> overflow_flag_out)
		else $error("overflow flag dropped");
	a_wake_pulse: assert property (wake_out |-> $past(sleep_in) ##1 !wake_out)
		else $error("wake pulse wrong");
	a_reset_clear: assert property (p_reset_clear)
		else $error("reset did not clear state");
endmodule

bind gated_timer gtimer_assertions u_chk (.sys_clk_in, .rst_in, .timer_on_bit_in,
	.gate_enable_bit_in, .clock_select_field_in, .prescale_select_field_in, .gate_polarity_bit_in,
	.gate_source_select_bit_in, .toggle_mode_bit_in, .count_low_wr_in, .count_high_wr_in,
	.count_wr_data_in, .overflow_flag_clr_in, .sleep_in, .external_gate_pin_in,
	.count_low_byte_out, .count_high_byte_out, .overflow_flag_out, .wake_out);

`default_nettype wire

/* bench/far_side.sv */
// model of the pins and companion timer around the gated timer
// assumes the bench calls send for count pulses and drives the gate level
`timescale 1ns/1ps
`default_nettype none

module far_side (
	// clock
	input wire logic	sys_clk_in,
	// bench commands
	input wire logic	gate_lvl_in,
	input wire logic	comp_run_in,
	// pins and companion count
	output logic		ext_count_out,
	output logic		ext_gate_out,
	output logic		lf_osc_out,
	output logic [7:0]	comp_count_out
);
	int lf_n;
	// gate pin follows the level the bench asks for
	assign ext_gate_out = gate_lvl_in;
	initial begin
		ext_count_out = 1'b0;
		lf_osc_out <= 1'b0;
		comp_count_out <= 8'h00;
		lf_n <= 0;
	end
	// slow oscillator runs free with a 16-clock period; companion wraps FFh to 00h
	always @(negedge sys_clk_in) begin
		lf_n <= (lf_n + 1) % 8;
		if (lf_n == 7) lf_osc_out <= ~lf_osc_out;
		if (comp_run_in) comp_count_out <= comp_count_out + 8'h01;
	end
	// burst of pulses, pin idles low so the burst opens with a rise
	task automatic send(input int m, h);
		repeat (m) begin
			repeat (h) @(negedge sys_clk_in);
			ext_count_out = 1'b1;
			repeat (h) @(negedge sys_clk_in);
			ext_count_out = 1'b0;
		end
		repeat (h) @(negedge sys_clk_in);
	endtask
endmodule

`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the gated 16-bit timer/counter
// assumes the design package, the far side model and the bound checker
`timescale 1ns/1ps
`default_nettype none

module tb;
	import gtimer_pkg::*;
	logic		sys_clk_in, rst_in, on, ge, sd, pol, gss, tgl, wl, wh, clr, slp, glvl, crun;
	logic		ecp, egp, lfo, flag, wake, gval, woke;
	logic [1:0]	sel, psc;
	logic [7:0]	wd, lo, hi, cc;
	logic [15:0]	v, c;
	int		bad_count, checks_done, n, k;
	wire logic [15:0] cnt = {hi, lo};

	gated_timer u_dut (
		.sys_clk_in, .rst_in, .timer_on_bit_in(on), .gate_enable_bit_in(ge),
		.clock_select_field_in(sel), .prescale_select_field_in(psc), .sync_disable_bit_in(sd),
		.gate_polarity_bit_in(pol), .gate_source_select_bit_in(gss), .toggle_mode_bit_in(tgl),
		.count_low_wr_in(wl), .count_high_wr_in(wh), .count_wr_data_in(wd),
		.overflow_flag_clr_in(clr), .sleep_in(slp), .external_count_pin_in(ecp),
		.external_gate_pin_in(egp), .low_freq_internal_osc_in(lfo), .companion_timer_count_in(cc),
		.count_low_byte_out(lo), .count_high_byte_out(hi), .overflow_flag_out(flag),
		.wake_out(wake), .gate_value_out(gval)
	);
	far_side u_far (.sys_clk_in, .gate_lvl_in(glvl), .comp_run_in(crun), .ext_count_out(ecp),
		.ext_gate_out(egp), .lf_osc_out(lfo), .comp_count_out(cc));

	// ----------------------------------------
	// clock, wake watch and helpers
	// ----------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) if (wake === 1'b1) woke = 1'b1;
	// counts expected from a run of m clocks on source s with prescale p
	function automatic logic [15:0] rate(input int s, p, m);
		return 16'(((s == 1) ? m : (s == 0) ? m / 4 : m / 16) >> p);
	endfunction
	task automatic tick(input int m);
		repeat (m) @(negedge sys_clk_in);
	endtask
	task automatic cmp(input logic [15:0] g, e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// tolerant compare where phase against the source is free
	task automatic near(input logic [15:0] g, e, input int t);
		checks_done++;
		if ($isunknown(g) || (16'(g - e) > t && 16'(e - g) > t)) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// low byte then high byte, back to back
	task automatic wr(input logic [15:0] x);
		wl = 1'b1;
		wd = x[7:0];
		tick(1);
		wl = 1'b0;
		wh = 1'b1;
		wd = x[15:8];
		tick(1);
		wh = 1'b0;
	endtask
	task automatic run(input int m);
		on = 1'b1;
		tick(m);
		on = 1'b0;
		tick(2);
	endtask
	task automatic pulse();
		glvl = 1'b1;
		tick(2);
		glvl = 1'b0;
	endtask
	task automatic done(input string t);
		$display("test %s finished", t);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{on, ge, sd, pol, gss, tgl, wl, wh, clr, slp, glvl, crun, woke} = '0;
		sel = CLKSEL_INSTR;
		psc = PSC_DIV1;
		wd = 8'h00;
		bad_count = 0;
		checks_done = 0;
		n = $urandom(32'h55BDC2D5);
		rst_in = 1'b1;
		tick(2);
		rst_in = 1'b0;
		tick(3);
		cmp(cnt, 16'h0000);
		cmp(16'(flag), 16'h0000);
		done("reset");
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 4; p++) begin
				if (s == 2) continue;
				sel = 2'(s);
				psc = 2'(p);
				n = 16 * (1 + $urandom % 8);
				v = 16'($urandom);
				wr(v);
				run(n);
				cmp(cnt, v + rate(s, p, n));
			end
		end
		done("rates");
		sel = CLKSEL_EXTPIN;
		psc = PSC_DIV1;
		for (int a = 0; a < 2; a++) begin
			sd = a[0];
			slp = a[0];
			woke = 1'b0;
			k = 17 + $urandom % 8;
			wr(16'hFFF0);
			on = 1'b1;
			u_far.send(k, 2 + $urandom % 3);
			tick(6);
			on = 1'b0;
			slp = 1'b0;
			cmp(cnt, 16'hFFF0 + 16'(k - 1));
			cmp(16'(flag), 16'h0001);
			cmp(16'(woke), 16'(a));
			clr = 1'b1;
			tick(1);
			clr = 1'b0;
			tick(1);
			cmp(16'(flag), 16'h0000);
		end
		// flipping the bypass mid-count may drop or add one count
		wr(16'h0100);
		on = 1'b1;
		u_far.send(5, 3);
		sd = ~sd;
		u_far.send(5, 3);
		tick(6);
		on = 1'b0;
		near(cnt, 16'h0109, 1);
		// a synchronous source freezes while asleep
		sel = CLKSEL_SYSOSC;
		slp = 1'b1;
		c = cnt;
		run(20);
		cmp(cnt, c);
		slp = 1'b0;
		done("external");
		sel = CLKSEL_SYSOSC;
		ge = 1'b1;
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			glvl = p[0];
			tick(4);
			v = 16'($urandom);
			n = 20 + $urandom % 50;
			wr(v);
			run(n);
			cmp(cnt, v + 16'(n));
			cmp(16'(gval), 16'h0001);
			glvl = ~glvl;
			tick(4);
			run(n);
			cmp(cnt, v + 16'(n));
			cmp(16'(gval), 16'h0000);
		end
		done("gate pin");
		gss = 1'b1;
		pol = 1'b1;
		crun = 1'b1;
		v = 16'($urandom);
		wr(v);
		run(512);
		near(cnt, v + 16'h0002, 1);
		gss = 1'b0;
		tgl = 1'b1; // polarity left as it was
		wr(v);
		on = 1'b1;
		pulse();
		tick(100);
		pulse();
		tick(50);
		on = 1'b0;
		near(cnt, v + 16'h0066, 2);
		for (int w = 0; w < 2; w++) begin
			on = 1'b1;
			pulse();
			tick(10);
			if (w == 0) tgl = 1'b0;
			else on = 1'b0;
			tick(2);
			tgl = 1'b1;
			on = 1'b1;
			tick(4);
			c = cnt;
			tick(20);
			cmp(cnt, c);
		end
		on = 1'b0;
		done("companion and toggle");
		conclude();
	end
	// watchdog well beyond the planned run
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
endmodule

`default_nettype wire
